// ### core/duart_pkg.sv
// package: register map, field positions, reset values and constants of the dual uart channel
package duart_pkg;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LCR = 3'h3;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SPR = 3'h7;
    localparam logic [7:0] LCR_ENH_KEY = 8'hbf;
    localparam int LCR_DIV_BIT = 7;
    localparam int EFR_ENH_BIT = 4;
    localparam int MCR_DTR_BIT = 0;
    localparam int MCR_RTS_BIT = 1;
    localparam int MCR_IRINV_BIT = 2;
    localparam int MCR_OP2_BIT = 3;
    localparam int MCR_LOOP_BIT = 4;
    localparam logic [7:0] ENH_FIELD_MASK = 8'hf0;
    localparam logic [7:0] MCR_ENH_MASK = 8'he0;
    localparam logic [7:0] ISR_ENH_MASK = 8'h30;
    localparam logic [7:0] FCR_ENH_MASK = 8'h30;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] ISR_NO_INT = 8'h01;
    localparam logic [7:0] DIV_ZERO = 8'h00;
    // arbitrary identity values, then default fifo depth and transmit shifter bit count
    localparam logic [7:0] REV_CODE_DEFAULT = 8'h01;
    localparam logic [7:0] ID_CODE_DEFAULT = 8'h5a;
    localparam int FIFO_DEPTH_DEFAULT = 4;
    localparam logic [3:0] BIT_COUNT = 4'h9;
endpackage : duart_pkg

// ### core/duart_fifo.sv
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/100ps
module duart_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } duart_fifo_st_t;
    duart_fifo_st_t s_r, s_nxt;
    logic push, pop;
    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction : inc
    always_comb begin
        s_nxt = s_r;
        push = in_valid && (s_r.cnt != (AW+1)'(DEPTH));
        pop = out_ready && (s_r.cnt != '0);
        if (push) begin
            s_nxt.mem[s_r.wp] = in_data;
            s_nxt.wp = inc(s_r.wp);
        end
        if (pop) begin
            s_nxt.rp = inc(s_r.rp);
        end
        if (push && !pop) begin
            s_nxt.cnt = (AW+1)'(s_r.cnt + 1'b1);
        end else if (pop && !push) begin
            s_nxt.cnt = (AW+1)'(s_r.cnt - 1'b1);
        end
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end
    assign in_ready = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (s_r.cnt != '0);
    assign out_data = s_r.mem[s_r.rp];
endmodule : duart_fifo

// ### core/duart_chan.sv
// one uart channel: register decode, banking, loopback, minimal serial engine
//
// Contract
// (RULE1) Modem control bit 4 set puts the channel in internal loopback while everything else keeps working.
// (RULE2) In loopback the transmit shift output feeds the receive shift input directly.
// (RULE3) In loopback the tx, rts and dtr pins hold idle and the four modem inputs are ignored.
// (RULE4) Automatic rts/cts flow control is held inactive during loopback.
// (RULE5) The far end keeps the serial receive pin high throughout a loopback test.
// (RULE6) The channel owns its register set, picked by three address lines and its own active-low select.
// (RULE7) Address 0 with line control bit 7 clear reads received data and writes transmit holding.
// (RULE8) With bit 7 set and line control not the key, addresses 0 and 1 reach the divisor bytes.
// (RULE9) Address 2 reaches the fractional divisor only with bit 7 set, no key, and enhanced bit 4 set.
// (RULE10) With both divisor bytes zero in the divisor bank, reads at 0 and 1 give revision and id codes.
// (RULE11) Address 1 reaches interrupt enable whenever line control bit 7 is clear.
// (RULE12) Address 2 without the key reads interrupt status and writes fifo control, except where RULE9 gives the fractional divisor.
// (RULE13) Address 3 is line control, and outside the enhanced bank 4, 5, 6, 7 are modem ctl, line and modem status, and scratch.
// (RULE14) With the key, address 2 is enhanced function and 4 to 7 are the two resume and two pause characters.
// (RULE15) Extended fields of ier, isr, fcr and mcr work only with enhanced bit 4 set, else read zero.
// (RULE16) Modem control bits are dtr, rts, ir invert, int enable, loopback, xon-any, ir mode, prescaler.
// (RULE17) In loopback the modem control outputs feed the modem status inputs.
`timescale 1ns/100ps
module duart_chan #(
    parameter int FIFO_DEPTH = duart_pkg::FIFO_DEPTH_DEFAULT,
    parameter logic [7:0] REV_CODE = duart_pkg::REV_CODE_DEFAULT,
    parameter logic [7:0] ID_CODE = duart_pkg::ID_CODE_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // host bus
    input wire logic chan_select_n,
    input wire logic [2:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    output logic rdata_oe,
    // serial and modem pins
    output logic tx_out,
    input wire logic rx_in,
    output logic rts_n,
    output logic dtr_n,
    output logic user_output_one_n,
    output logic user_output_two_n,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic cd_n,
    input wire logic ri_n,
    // status
    output logic loopback_active
);
    typedef struct packed {
        logic [7:0] interrupt_enable, line_control, modem_control, scratch_pad, enhanced_function, fifo_control, dll, baud_divisor_high, baud_divisor_fraction;
        logic [7:0] xon1, xon2, xoff1, xoff2;
        logic [7:0] rx_holding, rdata, msr_prev;
        logic rdv, oe, rd_q, wr_q, dr, ovr;
        logic tx_busy, tx_line, rts_q, dtr_q, op1, op2, loop;
        logic [8:0] tx_sh;
        logic [3:0] tx_cnt, rx_cnt;
        logic rx_busy;
        logic [7:0] rx_sh;
        logic [3:0] delta;
    } duart_chan_st_t;
    duart_chan_st_t s_r, s_nxt;
    logic tf_in_valid, tf_in_ready, tf_out_valid, tf_out_ready;
    logic [7:0] tf_out_data;
    logic rd_edge, wr_edge, enh, key, div_bank, div_zero, loop_now, rx_bit;
    logic [3:0] modem_in;
    logic [7:0] msr_val, lsr_val, isr_val, rd_val;
    // tx data buffer between holding register writes and the shifter
    duart_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
        .core_clk(core_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .in_valid(tf_in_valid),
        .in_ready(tf_in_ready),
        .in_data(wdata),
        .out_valid(tf_out_valid),
        .out_ready(tf_out_ready),
        .out_data(tf_out_data)
    );
    function automatic logic [7:0] gate_enh(input logic [7:0] v, input logic [7:0] m, input logic en);
        gate_enh = en ? v : (v & ~m);
    endfunction : gate_enh
    always_comb begin
        s_nxt = s_r;
        rd_edge = !chan_select_n && !rd_n && !s_r.rd_q; // [RULE6]
        wr_edge = !chan_select_n && !wr_n && !s_r.wr_q; // [RULE6]
        s_nxt.rd_q = !chan_select_n && !rd_n;
        s_nxt.wr_q = !chan_select_n && !wr_n;
        enh = s_r.enhanced_function[duart_pkg::EFR_ENH_BIT];
        key = (s_r.line_control == duart_pkg::LCR_ENH_KEY);
        div_bank = s_r.line_control[duart_pkg::LCR_DIV_BIT] && !key; // [RULE8]
        div_zero = (s_r.dll == duart_pkg::DIV_ZERO) && (s_r.baud_divisor_high == duart_pkg::DIV_ZERO);
        loop_now = s_r.modem_control[duart_pkg::MCR_LOOP_BIT]; // [RULE1]
        // loopback modem inputs come from modem control, pins ignored
        if (loop_now) begin
            modem_in = {s_r.modem_control[duart_pkg::MCR_OP2_BIT], s_r.modem_control[duart_pkg::MCR_IRINV_BIT],
                        s_r.modem_control[duart_pkg::MCR_DTR_BIT], s_r.modem_control[duart_pkg::MCR_RTS_BIT]}; // [RULE3] [RULE17]
        end else begin
            modem_in = {~cd_n, ~ri_n, ~dsr_n, ~cts_n};
        end
        msr_val = {modem_in, s_r.delta};
        lsr_val = {1'b0, !s_r.tx_busy && !tf_out_valid, tf_in_ready, 1'b0, 2'b00, s_r.ovr, s_r.dr};
        isr_val = gate_enh({s_r.fifo_control[0], s_r.fifo_control[0], 2'b00, duart_pkg::ISR_NO_INT[3:0]},
                           duart_pkg::ISR_ENH_MASK, enh); // [RULE15]
        s_nxt.delta = s_r.delta | (modem_in ^ s_r.msr_prev[3:0]);
        s_nxt.msr_prev = {4'h0, modem_in};
        // read decode
        rd_val = 8'h00;
        if (addr == duart_pkg::ADDR_LCR) begin
            rd_val = s_r.line_control; // [RULE13]
        end else if (addr == duart_pkg::ADDR_DATA && div_bank) begin
            rd_val = div_zero ? REV_CODE : s_r.dll; // [RULE8] [RULE10]
        end else if (addr == duart_pkg::ADDR_DATA && !s_r.line_control[duart_pkg::LCR_DIV_BIT]) begin
            rd_val = s_r.rx_holding; // [RULE7]
        end else if (addr == duart_pkg::ADDR_IER && div_bank) begin
            rd_val = div_zero ? ID_CODE : s_r.baud_divisor_high; // [RULE8] [RULE10]
        end else if (addr == duart_pkg::ADDR_IER && !s_r.line_control[duart_pkg::LCR_DIV_BIT]) begin
            rd_val = gate_enh(s_r.interrupt_enable, duart_pkg::ENH_FIELD_MASK, enh); // [RULE11] [RULE15]
        end else if (addr == duart_pkg::ADDR_ISR && key) begin
            rd_val = s_r.enhanced_function; // [RULE14]
        end else if (addr == duart_pkg::ADDR_ISR && div_bank && enh) begin
            rd_val = s_r.baud_divisor_fraction; // [RULE9]
        end else if (addr == duart_pkg::ADDR_ISR) begin
            rd_val = isr_val; // [RULE12]
        end else if (key && addr == duart_pkg::ADDR_MCR) begin
            rd_val = s_r.xon1; // [RULE14]
        end else if (key && addr == duart_pkg::ADDR_LSR) begin
            rd_val = s_r.xon2; // [RULE14]
        end else if (key && addr == duart_pkg::ADDR_MSR) begin
            rd_val = s_r.xoff1; // [RULE14]
        end else if (key && addr == duart_pkg::ADDR_SPR) begin
            rd_val = s_r.xoff2; // [RULE14]
        end else if (key) begin
            // nothing sits at 0 and 1 in the enhanced bank
            rd_val = 8'h00;
        end else if (addr == duart_pkg::ADDR_MCR) begin
            rd_val = gate_enh(s_r.modem_control, duart_pkg::MCR_ENH_MASK, enh); // [RULE15] [RULE16]
        end else if (addr == duart_pkg::ADDR_LSR) begin
            rd_val = lsr_val; // [RULE13]
        end else if (addr == duart_pkg::ADDR_MSR) begin
            rd_val = msr_val; // [RULE13]
        end else begin
            rd_val = s_r.scratch_pad; // [RULE13]
        end
        if (rd_edge) begin
            s_nxt.rdata = rd_val;
            if (addr == duart_pkg::ADDR_DATA && !s_r.line_control[duart_pkg::LCR_DIV_BIT]) begin
                s_nxt.dr = 1'b0;
            end
            if (addr == duart_pkg::ADDR_LSR && !key) begin
                s_nxt.ovr = 1'b0;
            end
            if (addr == duart_pkg::ADDR_MSR && !key) begin
                s_nxt.delta = modem_in ^ s_r.msr_prev[3:0];
            end
        end
        s_nxt.oe = !chan_select_n && !rd_n;
        // write decode
        tf_in_valid = 1'b0;
        if (wr_edge) begin
            if (addr == duart_pkg::ADDR_LCR) begin
                s_nxt.line_control = wdata; // [RULE13]
            end else if (addr == duart_pkg::ADDR_DATA && div_bank) begin
                s_nxt.dll = wdata; // [RULE8]
            end else if (addr == duart_pkg::ADDR_DATA && !s_r.line_control[duart_pkg::LCR_DIV_BIT]) begin
                tf_in_valid = 1'b1; // [RULE7]
            end else if (addr == duart_pkg::ADDR_IER && div_bank) begin
                s_nxt.baud_divisor_high = wdata; // [RULE8]
            end else if (addr == duart_pkg::ADDR_IER && !s_r.line_control[duart_pkg::LCR_DIV_BIT]) begin
                s_nxt.interrupt_enable = gate_enh(wdata, duart_pkg::ENH_FIELD_MASK, enh); // [RULE11] [RULE15]
            end else if (addr == duart_pkg::ADDR_ISR && key) begin
                s_nxt.enhanced_function = wdata; // [RULE14]
            end else if (addr == duart_pkg::ADDR_ISR && div_bank && enh) begin
                s_nxt.baud_divisor_fraction = wdata; // [RULE9]
            end else if (addr == duart_pkg::ADDR_ISR) begin
                s_nxt.fifo_control = gate_enh(wdata, duart_pkg::FCR_ENH_MASK, enh); // [RULE12] [RULE15]
            end else if (key && addr == duart_pkg::ADDR_MCR) begin
                s_nxt.xon1 = wdata; // [RULE14]
            end else if (key && addr == duart_pkg::ADDR_LSR) begin
                s_nxt.xon2 = wdata; // [RULE14]
            end else if (key && addr == duart_pkg::ADDR_MSR) begin
                s_nxt.xoff1 = wdata; // [RULE14]
            end else if (key && addr == duart_pkg::ADDR_SPR) begin
                s_nxt.xoff2 = wdata; // [RULE14]
            end else if (key) begin
                // writes at 0 and 1 in the enhanced bank must not land anywhere
                s_nxt.xoff2 = s_r.xoff2;
            end else if (addr == duart_pkg::ADDR_MCR) begin
                s_nxt.modem_control = gate_enh(wdata, duart_pkg::MCR_ENH_MASK, enh); // [RULE15] [RULE16]
            end else if (addr == duart_pkg::ADDR_SPR) begin
                s_nxt.scratch_pad = wdata; // [RULE13]
            end
        end
        // transmit shifter, one bit per enabled clock: start, 8 data, stop
        tf_out_ready = !s_r.tx_busy;
        if (!s_r.tx_busy && tf_out_valid) begin
            s_nxt.tx_busy = 1'b1;
            s_nxt.tx_sh = {tf_out_data, 1'b0};
            s_nxt.tx_cnt = duart_pkg::BIT_COUNT;
        end else if (s_r.tx_busy) begin
            s_nxt.tx_line = s_r.tx_sh[0];
            s_nxt.tx_sh = {1'b1, s_r.tx_sh[8:1]};
            s_nxt.tx_cnt = 4'(s_r.tx_cnt - 1'b1);
            if (s_r.tx_cnt == 4'h0) begin
                s_nxt.tx_busy = 1'b0;
                s_nxt.tx_line = 1'b1;
            end
        end
        // receiver input: loopback takes the shifter output, pin ignored
        rx_bit = loop_now ? s_r.tx_line : rx_in; // [RULE2] [RULE5]
        if (!s_r.rx_busy && !rx_bit) begin
            s_nxt.rx_busy = 1'b1;
            s_nxt.rx_cnt = 4'h8;
        end else if (s_r.rx_busy) begin
            s_nxt.rx_cnt = 4'(s_r.rx_cnt - 1'b1);
            if (s_r.rx_cnt != 4'h0) begin
                s_nxt.rx_sh = {rx_bit, s_r.rx_sh[7:1]};
            end else begin
                s_nxt.rx_busy = 1'b0;
                s_nxt.rx_holding = s_r.rx_sh;
                s_nxt.dr = 1'b1; // set wins over read clear
                s_nxt.ovr = s_nxt.ovr | s_r.dr;
            end
        end
        // pins hold idle in loopback
        s_nxt.loop = loop_now;
        s_nxt.rts_q = loop_now ? 1'b1 : !s_r.modem_control[duart_pkg::MCR_RTS_BIT]; // [RULE3] [RULE4]
        s_nxt.dtr_q = loop_now ? 1'b1 : !s_r.modem_control[duart_pkg::MCR_DTR_BIT]; // [RULE3]
        s_nxt.op1 = loop_now ? 1'b1 : !s_r.modem_control[duart_pkg::MCR_IRINV_BIT];
        s_nxt.op2 = loop_now ? 1'b1 : !s_r.modem_control[duart_pkg::MCR_OP2_BIT];
        s_nxt.rdv = loop_now ? 1'b1 : s_nxt.tx_line; // [RULE3]
    end
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.tx_line <= 1'b1;
            s_r.rdv <= 1'b1;
            s_r.rts_q <= 1'b1;
            s_r.dtr_q <= 1'b1;
            s_r.op1 <= 1'b1;
            s_r.op2 <= 1'b1;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end
    assign rdata = s_r.rdata;
    assign rdata_oe = s_r.oe;
    assign tx_out = s_r.rdv;
    assign rts_n = s_r.rts_q;
    assign dtr_n = s_r.dtr_q;
    assign user_output_one_n = s_r.op1;
    assign user_output_two_n = s_r.op2;
    assign loopback_active = s_r.loop;
endmodule : duart_chan

// ### tb/duart_chan_assertions.sv
// checker: register decode and loopback relations of one channel
`timescale 1ns/100ps
module duart_chan_assertions #(
    parameter logic [7:0] REV_CODE = duart_pkg::REV_CODE_DEFAULT,
    parameter logic [7:0] ID_CODE = duart_pkg::ID_CODE_DEFAULT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    // host bus
    input wire logic chan_select_n,
    input wire logic [2:0] addr,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rdata_oe,
    // serial and modem pins
    input wire logic tx_out,
    input wire logic rx_in,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic user_output_one_n,
    input wire logic user_output_two_n,
    input wire logic cts_n,
    input wire logic dsr_n,
    input wire logic cd_n,
    input wire logic ri_n,
    // status
    input wire logic loopback_active
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic rd_q, wr_q, efr4_s;
    logic [7:0] lcr_s, dll_s, dlm_s, ier_s, spr_s, mcr_s;
    wire rd_go = !chan_select_n && !rd_n && !rd_q;
    wire wr_go = !chan_select_n && !wr_n && !wr_q;
    wire bank_bf = lcr_s == 8'hbf;
    wire bank_dv = lcr_s[7] && !bank_bf;
    // shadow copies of six host-visible registers and enhanced bit 4
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            {rd_q, wr_q, efr4_s} <= 3'h0;
            {lcr_s, dll_s, dlm_s, ier_s, spr_s, mcr_s} <= 48'h0;
        end else if (clk_en) begin
            rd_q <= !chan_select_n && !rd_n;
            wr_q <= !chan_select_n && !wr_n;
            if (wr_go) begin
                if (addr == 3'h3) lcr_s <= wdata;
                if (addr == 3'h0 && bank_dv) dll_s <= wdata;
                if (addr == 3'h1 && bank_dv) dlm_s <= wdata;
                if (addr == 3'h1 && !lcr_s[7]) ier_s <= efr4_s ? wdata : (wdata & 8'h0f);
                if (addr == 3'h2 && bank_bf) efr4_s <= wdata[4];
                if (addr == 3'h4 && !bank_bf) mcr_s <= efr4_s ? wdata : (wdata & 8'h1f);
                if (addr == 3'h7 && !bank_bf) spr_s <= wdata;
            end
        end
    end
    sequence s_mcr_wr;
        wr_go && addr == 3'h4 && !bank_bf;
    endsequence
    sequence s_mcr_settled;
        s_mcr_wr ##1 !mcr_s[4];
    endsequence
    a_lcr_read: assert property (rd_go && addr == 3'h3 |=> rdata == lcr_s)
        else $error("line control readback wrong");
    a_spr_read: assert property (rd_go && addr == 3'h7 && !bank_bf |=> rdata == spr_s)
        else $error("scratch readback wrong");
    a_div_low: assert property (rd_go && addr == 3'h0 && bank_dv |=>
        rdata == (((dll_s | dlm_s) == 8'h00) ? REV_CODE : dll_s)) else $error("divisor low read wrong");
    a_div_high: assert property (rd_go && addr == 3'h1 && bank_dv |=>
        rdata == (((dll_s | dlm_s) == 8'h00) ? ID_CODE : dlm_s)) else $error("divisor high read wrong");
    a_ier_read: assert property (rd_go && addr == 3'h1 && !lcr_s[7] |=>
        rdata == (efr4_s ? ier_s : (ier_s & 8'h0f))) else $error("interrupt enable read wrong");
    a_isr_read: assert property (rd_go && addr == 3'h2 && !bank_bf && !(bank_dv && efr4_s) |=>
        rdata[3:0] == 4'h1 && (efr4_s || rdata[5:4] == 2'h0)) else $error("interrupt status read wrong");
    a_loop_follow: assert property (s_mcr_wr |-> ##2 loopback_active == mcr_s[4])
        else $error("loopback flag does not follow modem control");
    a_pins_follow: assert property (s_mcr_settled |=> rts_n == !mcr_s[1] && dtr_n == !mcr_s[0]
        && user_output_two_n == !mcr_s[3]) else $error("modem pins do not follow modem control");
    a_pins_held: assert property (loopback_active [*4] |-> tx_out && rts_n && dtr_n)
        else $error("pins move during loopback");
    a_oe_follow: assert property (rd_go |=> rdata_oe)
        else $error("read enable does not follow strobe");
endmodule : duart_chan_assertions
bind duart_chan duart_chan_assertions #(.REV_CODE(REV_CODE), .ID_CODE(ID_CODE)) duart_chan_assertions_inst (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .chan_select_n(chan_select_n), .addr(addr),
    .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe), .tx_out(tx_out),
    .rx_in(rx_in), .rts_n(rts_n), .dtr_n(dtr_n), .user_output_one_n(user_output_one_n),
    .user_output_two_n(user_output_two_n), .cts_n(cts_n), .dsr_n(dsr_n), .cd_n(cd_n), .ri_n(ri_n),
    .loopback_active(loopback_active));

// ### tb/duart_far_model.sv
// far-side model: serial line and modem inputs seen by one channel
`timescale 1ns/100ps
module duart_far_model (
    // clock
    input wire logic core_clk,
    // serial and modem lines
    output logic rx_in,
    output logic [3:0] modem_n
);
    logic [3:0] wig_r = 4'h5;
    assign rx_in = 1'b1;
    assign modem_n = wig_r;
    // modem inputs keep changing so loopback must ignore them
    always @(negedge core_clk) wig_r <= {wig_r[2:0], ~wig_r[3]};
endmodule : duart_far_model

// ### tb/tb_duart_chan.sv
// testbench: register map, banking, loopback and tx buffer of one channel
`timescale 1ns/100ps
module tb_duart_chan;
    logic core_clk, resetn, sel_n, csx, rd_n, wr_n, rdata_oe, tx_out, rx_in, rts_n, dtr_n, op1_n, op2_n, loop_on;
    logic full_seen;
    logic [2:0] addr;
    logic [3:0] modem_n;
    logic [7:0] wdata, rdata, got, seed;
    int err_total = 0;
    int samples_checked = 0;
    duart_chan duart_chan_inst (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1), .chan_select_n(sel_n),
        .addr(addr), .rd_n(rd_n), .wr_n(wr_n), .wdata(wdata), .rdata(rdata), .rdata_oe(rdata_oe),
        .tx_out(tx_out), .rx_in(rx_in), .rts_n(rts_n), .dtr_n(dtr_n), .user_output_one_n(op1_n),
        .user_output_two_n(op2_n), .cts_n(modem_n[3]), .dsr_n(modem_n[2]), .cd_n(modem_n[1]),
        .ri_n(modem_n[0]), .loopback_active(loop_on));
    duart_far_model duart_far_model_inst (.core_clk(core_clk), .rx_in(rx_in), .modem_n(modem_n));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic logic [7:0] ier_exp(input logic [7:0] v, input logic en);
        return en ? v : (v & 8'h0f);
    endfunction : ier_exp
    task automatic bus(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        addr = a;
        wdata = d;
        sel_n = csx;
        rd_n = wr;
        wr_n = !wr;
        repeat (2) @(negedge core_clk);
        got = rdata;
        {sel_n, rd_n, wr_n} = 3'h7;
    endtask : bus
    task automatic chk(input logic [7:0] e);
        samples_checked++;
        if (got !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        report_and_stop();
    end
    initial begin
        {resetn, csx, rd_n, wr_n, sel_n} = 5'h07;
        addr = 3'h0;
        wdata = 8'h00;
        seed = 8'h46;
        repeat (5) @(negedge core_clk);
        resetn = 1'b1;
        bus(0, 3'h3, 8'h00); chk(8'h00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            bus(1, 3'h7, seed); bus(0, 3'h7, 8'h00); chk(seed);
        end
        csx = 1'b1;
        bus(1, 3'h7, ~seed);
        csx = 1'b0;
        bus(0, 3'h7, 8'h00); chk(seed);
        bus(1, 3'h3, 8'hbf);
        bus(1, 3'h2, 8'h10);
        for (int a = 4; a < 8; a++) begin
            seed = lfsr(seed);
            bus(1, a[2:0], seed); bus(0, a[2:0], 8'h00); chk(seed);
        end
        bus(0, 3'h2, 8'h00); chk(8'h10);
        bus(1, 3'h0, 8'h00); bus(0, 3'h7, 8'h00); chk(seed);
        bus(1, 3'h3, 8'h80);
        bus(0, 3'h0, 8'h00); chk(duart_pkg::REV_CODE_DEFAULT);
        bus(0, 3'h1, 8'h00); chk(duart_pkg::ID_CODE_DEFAULT);
        bus(1, 3'h0, seed | 8'h01); bus(0, 3'h0, 8'h00); chk(seed | 8'h01);
        bus(0, 3'h1, 8'h00); chk(8'h00);
        bus(1, 3'h2, 8'h0c); bus(0, 3'h2, 8'h00); chk(8'h0c);
        bus(1, 3'h3, 8'h00);
        bus(1, 3'h1, 8'hff); bus(0, 3'h1, 8'h00); chk(ier_exp(8'hff, 1'b1));
        bus(0, 3'h2, 8'h00); got = got & 8'h0f; chk(8'h01);
        bus(1, 3'h2, 8'h01); bus(0, 3'h2, 8'h00); chk(8'hc1);
        bus(1, 3'h3, 8'hbf);
        bus(1, 3'h2, 8'h00);
        bus(1, 3'h3, 8'h00);
        bus(1, 3'h1, 8'hff); bus(0, 3'h1, 8'h00); chk(ier_exp(8'hff, 1'b0));
        bus(1, 3'h4, 8'he3); bus(0, 3'h4, 8'h00); chk(8'h03);
        got = {4'h0, op1_n, op2_n, rts_n, dtr_n}; chk(8'h0c);
        bus(1, 3'h4, 8'h13);
        got = {4'h0, loop_on, tx_out, rts_n, dtr_n}; chk(8'h0f);
        bus(0, 3'h6, 8'h00); got = got & 8'hf0; chk(8'h30);
        seed = lfsr(seed);
        bus(1, 3'h0, seed);
        got = 8'h00;
        for (int k = 0; k < 20 && got[0] !== 1'b1; k++) bus(0, 3'h5, 8'h00);
        bus(0, 3'h0, 8'h00); chk(seed);
        full_seen = 1'b0;
        for (int k = 0; k < 16; k++) begin
            seed = lfsr(seed);
            bus(1, 3'h0, seed);
            bus(0, 3'h5, 8'h00);
            if (got[5] === 1'b0) full_seen = 1'b1;
        end
        got = {7'h0, full_seen}; chk(8'h01);
        for (int k = 0; k < 100 && got[6] !== 1'b1; k++) bus(0, 3'h5, 8'h00);
        got = got & 8'h60; chk(8'h60);
        bus(1, 3'h4, 8'h00);
        @(negedge core_clk);
        resetn = 1'b0;
        repeat (2) @(negedge core_clk);
        resetn = 1'b1;
        bus(0, 3'h7, 8'h00); chk(8'h00);
        report_and_stop();
    end
endmodule : tb_duart_chan
